//--- rtl/vdi_map.svh
// Constants of the video decoder two-wire register access master.
// Assumes a 20 MHz system clock; included by its bare name.
`ifndef VDI_MAP_SVH
`define VDI_MAP_SVH

// System clock period and serial clock period, ns
`define VDI_MCLK_NS 50
`define VDI_SCL_NS 10000
// One quarter of a serial bit, in system clocks
`define VDI_QTR_CYC ((`VDI_SCL_NS) / (4 * `VDI_MCLK_NS))

// Post-write wait for the lower register range
`define VDI_WAIT_US 64
`define VDI_WAIT_CYC ((`VDI_WAIT_US * 1000 + `VDI_MCLK_NS - 1) / `VDI_MCLK_NS)
// Longer wait for registers that reinitialise the device
`define VDI_LONG_WAIT_CYC 20000

// Slave address bytes, write direction, per strap level
`define VDI_ADDR_SEL0 8'hb8
`define VDI_ADDR_SEL1 8'hba
// Direction bit values
`define VDI_DIR_WRITE 1'b0
`define VDI_DIR_READ 1'b1
// First subaddress that needs no post-write wait
`define VDI_NOWAIT_BASE 8'h90

`endif

//--- rtl/vdi_pkg.sv
// Types of the video decoder two-wire register access master.
// Assumes nothing of its surroundings.
package vdi_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BYTE,
    ST_LOAD,
    ST_WAIT,
    ST_STOP
  } vdi_state_t;

  // What the current byte slot carries
  typedef enum logic [1:0] {
    BY_ADDR,
    BY_SUB,
    BY_WDATA,
    BY_RDATA
  } vdi_byte_t;

endpackage : vdi_pkg

//--- rtl/vdi_sync.sv
// Two-flop synchroniser for one bus pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module vdi_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin in, synchronised level out
  input wire logic d,
  output logic q
);

  logic meta; // First stage, read only by q

  // Two stages; bus lines idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : vdi_sync

//--- rtl/vdi_master.sv
// Two-wire bus master for a video decoder's register port.
// Assumes open-drain pads and pull-ups outside; serial clock is made here.
// Summary of operation
// - Register read uses two separate bus transactions
// - Address phase: start, address, write bit
// - Then send one subaddress byte
// - Stop right after subaddress ack, no data
// - Data phase: new start, address, read bit
// - Master acks every byte but last
// - Last byte gets not-ack, then stop
// - Blind master inserts maximum wait always; this one waits after lower-range writes only and also follows clock stretching
// - Lower-range writes wait 64 us before stop
// - Reinitialising registers may need longer wait
`timescale 1ns/1ps
`include "vdi_map.svh"
module vdi_master #(
  parameter int QTR_CYC = `VDI_QTR_CYC,
  parameter int WAIT_CYC = `VDI_WAIT_CYC,
  parameter int LONG_WAIT_CYC = `VDI_LONG_WAIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_reinit,
  input wire logic [7:0] cmd_subaddr,
  input wire logic [7:0] cmd_count,
  output logic cmd_ready,
  // Write data
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // Read data
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Status
  output logic busy,
  output logic done,
  output logic nack_err,
  // Level the device's strap is tied to
  input wire logic bus_address_select_strap,
  // Bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  vdi_pkg::vdi_state_t state, next_state; // Sequencer
  vdi_pkg::vdi_byte_t kind, next_kind; // Byte slot type
  logic [1:0] q, next_q; // Quarter of a bit
  logic [15:0] qcnt, next_qcnt; // Cycles within quarter
  logic [3:0] bitn, next_bitn; // Bit 0..7, 8 is ack
  logic [7:0] sh, next_sh; // Shift register
  logic [7:0] rem, next_rem; // Data bytes still to go
  logic [7:0] ptr, next_ptr; // Mirror of device pointer
  logic is_read, next_is_read; // Command is a read
  logic phase2, next_phase2; // Read data phase running
  logic long_w, next_long_w; // Use the long wait
  logic [6:0] dev, next_dev; // Seven-bit slave address
  logic [19:0] wcnt, next_wcnt; // Post-write wait count
  logic next_cmd_ready, next_wr_ready, next_rd_valid;
  logic [7:0] next_rd_data;
  logic next_busy, next_done, next_nack_err;
  logic next_scl_oe, next_sda_oe;
  logic scl_s, sda_s, strap_s; // Synchronised pins and strap level
  logic qtick, hold, ack, take_cmd;

  // Quarter length and wait loads at register width
  localparam logic [15:0] QLAST = 16'(QTR_CYC - 1);
  localparam logic [19:0] WLOAD = 20'(WAIT_CYC - 1);
  localparam logic [19:0] LLOAD = 20'(LONG_WAIT_CYC - 1);

  // Pin synchronisers
  vdi_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clk(mclk),
    .rst(rst),
    .d(scl_i),
    .q(scl_s)
  );
  vdi_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clk(mclk),
    .rst(rst),
    .d(sda_i),
    .q(sda_s)
  );
  // Strap is a board level, so it is synchronised like a pin
  vdi_sync #(.RST_VAL(1'b0)) u_strap_sync (
    .clk(mclk),
    .rst(rst),
    .d(bus_address_select_strap),
    .q(strap_s)
  );

  assign qtick = (qcnt == QLAST);
  // Clock high phase of byte and stop bits counts only once the line is really high
  assign hold = (state == vdi_pkg::ST_BYTE || state == vdi_pkg::ST_STOP)
      && q == 2'd2 && !scl_s;
  assign ack = !sda_s;
  assign take_cmd = cmd_valid && cmd_ready;

  // Next-state logic of the whole sequencer
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_q = q;
    next_qcnt = qcnt;
    next_bitn = bitn;
    next_sh = sh;
    next_rem = rem;
    next_ptr = ptr;
    next_is_read = is_read;
    next_phase2 = phase2;
    next_long_w = long_w;
    next_dev = dev;
    next_wcnt = wcnt;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    next_nack_err = nack_err;
    // Quarter timer for the bit-level states
    if (state == vdi_pkg::ST_START || state == vdi_pkg::ST_BYTE
        || state == vdi_pkg::ST_STOP) begin
      if (hold) begin
        next_qcnt = qcnt;
      end else if (qtick) begin
        next_qcnt = 16'h0000;
        next_q = q + 2'd1;
      end else begin
        next_qcnt = qcnt + 16'h0001;
      end
    end
    unique case (state)
      vdi_pkg::ST_IDLE: begin
        if (take_cmd) begin
          next_is_read = cmd_read;
          next_long_w = cmd_reinit;
          next_ptr = cmd_subaddr;
          next_rem = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
          // Write address picks the read one by its low bit
          next_dev = strap_s ? 7'(`VDI_ADDR_SEL1 >> 1)
              : 7'(`VDI_ADDR_SEL0 >> 1);
          next_phase2 = 1'b0;
          next_nack_err = 1'b0;
          next_q = 2'd0;
          next_qcnt = 16'h0000;
          next_state = vdi_pkg::ST_START;
        end
      end
      vdi_pkg::ST_START: begin
        if (qtick && q == 2'd2) begin
          // Direction bit: write for phase one, read for phase two
          next_sh = {dev, phase2 ? `VDI_DIR_READ : `VDI_DIR_WRITE};
          next_kind = vdi_pkg::BY_ADDR;
          next_bitn = 4'd0;
          next_q = 2'd0;
          next_state = vdi_pkg::ST_BYTE;
        end
      end
      vdi_pkg::ST_BYTE: begin
        if (qtick && q == 2'd3 && !hold) begin
          next_q = 2'd0;
          if (bitn != 4'd8) begin
            // MSB first out; the same shift gathers read bits
            next_sh = {sh[6:0], sda_s};
            next_bitn = bitn + 4'd1;
          end else begin
            next_bitn = 4'd0;
            unique case (kind)
              vdi_pkg::BY_ADDR: begin
                if (!ack) begin
                  next_nack_err = 1'b1;
                  next_state = vdi_pkg::ST_STOP;
                end else if (phase2) begin
                  next_kind = vdi_pkg::BY_RDATA;
                end else begin
                  next_kind = vdi_pkg::BY_SUB;
                  next_sh = ptr;
                end
              end
              vdi_pkg::BY_SUB: begin
                if (!ack) begin
                  next_nack_err = 1'b1;
                  next_state = vdi_pkg::ST_STOP;
                end else if (is_read) begin
                  next_state = vdi_pkg::ST_STOP;
                end else begin
                  next_state = vdi_pkg::ST_LOAD;
                end
              end
              vdi_pkg::BY_WDATA: begin
                if (!ack) begin
                  next_nack_err = 1'b1;
                  next_state = vdi_pkg::ST_STOP;
                end else begin
                  next_ptr = ptr + 8'h01;
                  next_rem = rem - 8'h01;
                  if (ptr < `VDI_NOWAIT_BASE) begin
                    // Wait whether or not the device stretches
                    next_wcnt = long_w ? LLOAD : WLOAD;
                    next_state = vdi_pkg::ST_WAIT;
                  end else if (rem == 8'h01) begin
                    next_state = vdi_pkg::ST_STOP;
                  end else begin
                    next_state = vdi_pkg::ST_LOAD;
                  end
                end
              end
              vdi_pkg::BY_RDATA: begin
                next_rd_data = sh;
                next_rd_valid = 1'b1;
                next_ptr = ptr + 8'h01;
                next_rem = rem - 8'h01;
                if (rem == 8'h01) begin
                  next_state = vdi_pkg::ST_STOP;
                end
              end
            endcase
          end
        end
      end
      vdi_pkg::ST_LOAD: begin
        // Serial clock stays low until data arrives
        if (wr_valid && wr_ready) begin
          next_sh = wr_data;
          next_kind = vdi_pkg::BY_WDATA;
          next_bitn = 4'd0;
          next_q = 2'd0;
          next_qcnt = 16'h0000;
          next_state = vdi_pkg::ST_BYTE;
        end
      end
      vdi_pkg::ST_WAIT: begin
        if (wcnt == 20'h00000) begin
          next_q = 2'd0;
          next_qcnt = 16'h0000;
          next_state = (rem == 8'h00) ? vdi_pkg::ST_STOP : vdi_pkg::ST_LOAD;
        end else begin
          next_wcnt = wcnt - 20'h00001;
        end
      end
      vdi_pkg::ST_STOP: begin
        if (qtick && q == 2'd3) begin
          next_q = 2'd0;
          if (!nack_err && is_read && !phase2) begin
            // Second transaction fetches the data
            next_phase2 = 1'b1;
            next_state = vdi_pkg::ST_START;
          end else begin
            next_done = 1'b1;
            next_state = vdi_pkg::ST_IDLE;
          end
        end
      end
    endcase
    next_cmd_ready = (next_state == vdi_pkg::ST_IDLE);
    next_wr_ready = (next_state == vdi_pkg::ST_LOAD);
    next_busy = (next_state != vdi_pkg::ST_IDLE);
  end

  // Pin drive; data changes a quarter after the clock falls
  always_comb begin
    next_scl_oe = 1'b0;
    next_sda_oe = sda_oe;
    unique case (state)
      vdi_pkg::ST_IDLE: begin
        next_sda_oe = 1'b0;
      end
      vdi_pkg::ST_START: begin
        next_scl_oe = (q == 2'd2);
        next_sda_oe = (q != 2'd0);
      end
      vdi_pkg::ST_BYTE: begin
        next_scl_oe = (q < 2'd2);
        if (q == 2'd1) begin
          if (bitn != 4'd8) begin
            next_sda_oe = (kind != vdi_pkg::BY_RDATA) && !sh[7];
          end else begin
            // Ack all read bytes but the last
            next_sda_oe = (kind == vdi_pkg::BY_RDATA) && rem != 8'h01;
          end
        end
      end
      vdi_pkg::ST_LOAD, vdi_pkg::ST_WAIT: begin
        next_scl_oe = 1'b1;
        next_sda_oe = 1'b0;
      end
      vdi_pkg::ST_STOP: begin
        next_scl_oe = (q < 2'd2);
        if (q == 2'd1) begin
          next_sda_oe = 1'b1;
        end else if (q == 2'd3) begin
          next_sda_oe = 1'b0;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= vdi_pkg::ST_IDLE;
      kind <= vdi_pkg::BY_ADDR;
      q <= 2'd0;
      qcnt <= 16'h0000;
      bitn <= 4'd0;
      sh <= 8'h00;
      rem <= 8'h00;
      ptr <= 8'h00;
      is_read <= 1'b0;
      phase2 <= 1'b0;
      long_w <= 1'b0;
      dev <= 7'h00;
      wcnt <= 20'h00000;
      cmd_ready <= 1'b1;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      q <= next_q;
      qcnt <= next_qcnt;
      bitn <= next_bitn;
      sh <= next_sh;
      rem <= next_rem;
      ptr <= next_ptr;
      is_read <= next_is_read;
      phase2 <= next_phase2;
      long_w <= next_long_w;
      dev <= next_dev;
      wcnt <= next_wcnt;
      cmd_ready <= next_cmd_ready;
      wr_ready <= next_wr_ready;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      busy <= next_busy;
      done <= next_done;
      nack_err <= next_nack_err;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_o <= 1'b0; // Open drain: only ever pulls low
      sda_o <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic end_slot; // Ack slot finishing this cycle
  assign end_slot = state == vdi_pkg::ST_BYTE && bitn == 4'd8 && qtick
      && q == 2'd3 && !hold;

  addr_byte_a: assert property (
    (state == vdi_pkg::ST_BYTE && kind == vdi_pkg::BY_ADDR && bitn == 4'd0)
      |-> sh == {dev, phase2}
  ) else $error("address byte or direction bit wrong");

  sub_stop_a: assert property (
    (end_slot && kind == vdi_pkg::BY_SUB && is_read && ack)
      |=> state == vdi_pkg::ST_STOP
  ) else $error("no stop after read subaddress");

  second_phase_a: assert property (
    (state == vdi_pkg::ST_STOP && qtick && q == 2'd3 && is_read && !phase2
      && !nack_err) |=> state == vdi_pkg::ST_START && phase2
  ) else $error("read data phase not started");

  rd_ack_a: assert property (
    (state == vdi_pkg::ST_BYTE && kind == vdi_pkg::BY_RDATA && bitn == 4'd8
      && q == 2'd3 && rem != 8'h01) |-> sda_oe
  ) else $error("read byte not acknowledged");

  rd_nack_a: assert property (
    (end_slot && kind == vdi_pkg::BY_RDATA && rem == 8'h01)
      |-> !sda_oe ##1 state == vdi_pkg::ST_STOP
  ) else $error("last read byte not closed by nack and stop");

  stretch_wait_a: assert property (
    hold |=> $stable(qcnt) && q == 2'd2 && !scl_oe
  ) else $error("clock high phase ran while line held low");

  low_wait_a: assert property (
    (end_slot && kind == vdi_pkg::BY_WDATA && ack && ptr < `VDI_NOWAIT_BASE
      && !long_w) |=> state == vdi_pkg::ST_WAIT [*8] ##1 wcnt == WLOAD - 20'd8
  ) else $error("post-write wait missing");

  hi_nowait_a: assert property (
    (end_slot && kind == vdi_pkg::BY_WDATA && ack && ptr >= `VDI_NOWAIT_BASE)
      |=> state != vdi_pkg::ST_WAIT
  ) else $error("needless wait for upper range");

  ptr_step_a: assert property (
    (end_slot && (kind == vdi_pkg::BY_RDATA || kind == vdi_pkg::BY_WDATA && ack))
      |=> ptr == $past(ptr) + 8'h01
  ) else $error("pointer did not advance");

endmodule : vdi_master

//--- verification/vdi_dev_model.sv
// Behavioural model of the video decoder's two-wire register port.
// Assumes resolved bus levels with pull-ups made by the bench.
`timescale 1ns/1ps
module vdi_dev_model (
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Strap level and clock hold length in ns
  input wire logic strap,
  input wire logic [15:0] hold_ns,
  // Pulls on the lines, high = drive low
  output logic sda_pull,
  output logic scl_hold
);
  logic [7:0] regs [256]; // Register bank
  logic [7:0] sh; // Incoming byte
  logic [7:0] ptr; // Register pointer, kept across stops
  logic act; // Addressed frame in progress
  logic rd; // Direction bit
  logic pend; // Clock hold owed after a data ack
  int bitn; // Slot within the nine-bit frame
  int ph; // 0 addr, 1 sub, 2 write data, 3 read data

  // Arbitrary contents so reads have something to return
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
    {sda_pull, scl_hold, act, rd, pend} = 5'h00;
    ptr = 8'h00;
    sh = 8'h00;
    bitn = 0;
    ph = 0;
  end

  // Start opens a frame; stop closes it but keeps the pointer
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    bitn = 0;
    ph = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end

  // Sample bits, and the master's acknowledge on reads
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (ph == 3 && sda) act = 1'b0; // Not-ack: release and idle
    else if (ph == 3) ptr = ptr + 8'h01; // Next register
    else if (ph == 0) ph = rd ? 3 : 1;
    else ph = 2;
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end

  // Drive acknowledge or read data while the clock is low
  always @(negedge scl) if (act) begin
    sda_pull = 1'b0;
    if (bitn == 8 && ph == 0) begin
      act = (sh[7:1] == {6'b101110, strap}); // Own address only
      rd = sh[0];
      sda_pull = act;
    end else if (bitn == 8 && ph < 3) begin
      sda_pull = 1'b1;
      if (ph == 1) ptr = sh;
      else begin
        regs[ptr] = sh;
        pend = (ptr < 8'h90); // Lower range needs processing time
        ptr = ptr + 8'h01;
      end
    end else if (ph == 3 && bitn < 8) sda_pull = !regs[ptr][7 - bitn]; // MSB first
  end

  // Hold the clock low once the write ack slot ends
  always @(negedge scl) if (pend && bitn == 0) begin
    pend = 1'b0;
    scl_hold = 1'b1;
    #(hold_ns) scl_hold = 1'b0;
  end
endmodule : vdi_dev_model

//--- verification/vdi_master_tb_top.sv
// Self-checking bench for the two-wire register access master.
// Assumes the device model is compiled before this file.
`timescale 1ns/1ps
module vdi_master_tb_top;
  localparam int WC = 20; // Short lower-range wait
  localparam int LWC = 50; // Short reinit wait
  localparam int LIM = 5000; // Bound on one command, in cycles

  // Command and window for the longest clock-low run
  typedef struct packed {
    logic rd;
    logic ri;
    logic strap;
    logic [7:0] sub;
    logic [7:0] cnt;
    logic [7:0] wd;
    logic [7:0] lo;
    logic [7:0] hi;
  } vdi_row_t;

  // Ordinary cases
  localparam vdi_row_t ROWS [10] = '{
    '{1'b0, 1'b0, 1'b0, 8'h10, 8'h02, 8'ha1, 8'd20, 8'd49},
    '{1'b0, 1'b0, 1'b1, 8'h9f, 8'h01, 8'h3c, 8'd0, 8'd19},
    '{1'b0, 1'b1, 1'b0, 8'h20, 8'h01, 8'h77, 8'd50, 8'd200},
    '{1'b0, 1'b0, 1'b1, 8'h8f, 8'h02, 8'hc4, 8'd20, 8'd49},
    '{1'b0, 1'b0, 1'b0, 8'h30, 8'h00, 8'h5e, 8'd20, 8'd49},
    '{1'b1, 1'b0, 1'b0, 8'h10, 8'h03, 8'h00, 8'd0, 8'd19},
    '{1'b1, 1'b0, 1'b1, 8'h8f, 8'h02, 8'h00, 8'd0, 8'd19},
    '{1'b1, 1'b0, 1'b0, 8'hff, 8'h01, 8'h00, 8'd0, 8'd19},
    '{1'b1, 1'b0, 1'b1, 8'h20, 8'h01, 8'h00, 8'd0, 8'd19},
    '{1'b1, 1'b0, 1'b0, 8'h30, 8'h02, 8'h00, 8'd0, 8'd19}
  };

  // Design ports and bench state
  logic mclk, rst, cmd_valid, cmd_read, cmd_reinit, cmd_ready, wr_valid, wr_ready;
  logic rd_valid, busy, done, nack_err, strap, dev_strap, scl_o, scl_oe, sda_o, sda_oe;
  logic dev_sda, dev_scl, scl_w, sda_w;
  logic [7:0] cmd_subaddr, cmd_count, wr_data, rd_data;
  logic [15:0] hold_ns; // Device clock hold length
  logic [7:0] exp_regs [256]; // Expected device contents
  int num_errors, total_checks, run, max_run;
  int takes; // Write bytes taken by the design in this command

  // Open-drain lines with pull-ups
  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~dev_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~dev_sda;

  vdi_master #(.QTR_CYC(4), .WAIT_CYC(WC), .LONG_WAIT_CYC(LWC)) dut (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_reinit(cmd_reinit), .cmd_subaddr(cmd_subaddr), .cmd_count(cmd_count),
    .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done), .nack_err(nack_err),
    .bus_address_select_strap(strap), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));

  vdi_dev_model dev (.scl(scl_w), .sda(sda_w), .strap(dev_strap), .hold_ns(hold_ns),
    .sda_pull(dev_sda), .scl_hold(dev_scl));

  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Next write byte after each take; longest clock-low run
  always @(posedge mclk) begin
    if (wr_valid && wr_ready) begin
      wr_data <= wr_data + 8'h01;
      takes++;
    end
    run = scl_w ? 0 : run + 1;
    if (run > max_run) max_run = run;
  end

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_byte(what, {7'h00, e}, {7'h00, g});
  endtask : chk_bit

  // Outputs while reset is held
  task automatic chk_idle();
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    chk_bit("busy", 1'b0, busy);
    chk_bit("done", 1'b0, done);
    chk_bit("scl_oe", 1'b0, scl_oe);
    chk_bit("sda_oe", 1'b0, sda_oe);
    chk_bit("wr_ready", 1'b0, wr_ready);
    chk_bit("rd_valid", 1'b0, rd_valid);
    chk_bit("nack_err", 1'b0, nack_err);
    chk_bit("scl_o", 1'b0, scl_o);
    chk_bit("sda_o", 1'b0, sda_o);
  endtask : chk_idle

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Present one command; the strap settles through its synchroniser first
  task automatic issue(input vdi_row_t r);
    @(posedge mclk);
    strap <= r.strap;
    repeat (3) @(posedge mclk);
    max_run = 0;
    takes = 0;
    cmd_valid <= 1'b1;
    cmd_read <= r.rd;
    cmd_reinit <= r.ri;
    cmd_subaddr <= r.sub;
    cmd_count <= r.cnt;
    wr_valid <= !r.rd;
    wr_data <= r.wd;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask : issue

  // Run a command to done and check bytes, registers and waits
  task automatic run_cmd(input vdi_row_t r);
    int n;
    int k;
    logic [7:0] ce;
    n = 0;
    k = 0;
    ce = (r.cnt == 8'h00) ? 8'h01 : r.cnt;
    issue(r);
    do begin
      @(negedge mclk);
      n++;
      if (n == 1) chk_bit("busy", 1'b1, busy);
      if (rd_valid === 1'b1) begin
        chk_byte("rd_data", exp_regs[8'(r.sub + k)], rd_data);
        k++;
      end
    end while (done !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      num_errors++;
      $display("CHECK FAILED done expected 1 seen 0");
      tally_and_finish();
    end
    // Back to idle in the cycle of the done pulse
    chk_bit("busy", 1'b0, busy);
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    chk_bit("wr_ready", 1'b0, wr_ready);
    @(posedge mclk);
    wr_valid <= 1'b0;
    chk_bit("nack_err", r.strap !== dev_strap, nack_err);
    chk_byte("bytes written", (r.rd || r.strap !== dev_strap) ? 8'h00 : ce, 8'(takes));
    if (r.rd) chk_byte("bytes read", ce, 8'(k));
    for (int i = 0; i <= ce; i++) begin
      if (!r.rd && i < ce && !nack_err) exp_regs[8'(r.sub + i)] = 8'(r.wd + i);
      chk_byte("reg", exp_regs[8'(r.sub + i)], dev.regs[8'(r.sub + i)]);
    end
    chk_bit("low run", 1'b1, max_run >= r.lo && max_run <= r.hi);
    // Done stands for one cycle only
    @(negedge mclk);
    chk_bit("done", 1'b0, done);
    $display("test sub %h count %h done", r.sub, r.cnt);
  endtask : run_cmd

  // Main sequence
  initial begin
    {rst, cmd_valid, cmd_read, cmd_reinit, wr_valid, strap, dev_strap} = 7'h40;
    cmd_subaddr = 8'h00;
    cmd_count = 8'h00;
    wr_data = 8'h00;
    hold_ns = 16'd200;
    for (int i = 0; i < 256; i++) exp_regs[i] = 8'(i) ^ 8'h5a;
    num_errors = 0;
    total_checks = 0;
    run = 0;
    max_run = 0;
    takes = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk_idle();
    $display("test reset held done");
    @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      dev_strap = ROWS[i].strap;
      run_cmd(ROWS[i]);
    end
    // Strap disagrees with the device: address refused
    dev_strap = 1'b1;
    run_cmd('{1'b0, 1'b0, 1'b0, 8'h40, 8'h01, 8'h99, 8'd0, 8'd19});
    // Device holds the clock far past the master's own wait
    hold_ns = 16'd3000;
    run_cmd('{1'b0, 1'b0, 1'b1, 8'h50, 8'h01, 8'h0e, 8'd55, 8'd200});
    hold_ns = 16'd200;
    // Reset in mid-address byte, then recover
    issue('{1'b0, 1'b0, 1'b1, 8'h60, 8'h01, 8'h33, 8'd0, 8'd0});
    repeat (40) @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk_idle();
    $display("test reset in mid-run done");
    @(posedge mclk);
    rst <= 1'b0;
    wr_valid <= 1'b0;
    run_cmd('{1'b1, 1'b0, 1'b1, 8'h60, 8'h01, 8'h00, 8'd0, 8'd19});
    tally_and_finish();
  end
endmodule : vdi_master_tb_top
